// ### verilog/bkfc_pkg.sv
//------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------
// Overview of operation
// RULE_01 - feedback under threshold: both buck switches off, error pin low
// RULE_02 - undervoltage latches global, regulator and undervoltage flags
// RULE_03 - switching and error pin recover by themselves once voltage is back
// RULE_04 - undervolt flag sticky until clear command or long sleep-low pulse; code also clears it on a status read
// RULE_05 - overcurrent recognised only after continuous deglitch time
// RULE_06 - recognised overcurrent sets global, regulator, overcurrent flags
// RULE_07 - after retry time, switching restarts and error pin releases
// RULE_08 - overcurrent related flags held for retry period, cleared at end
// RULE_09 - pin variant fixed 600 mA limit; serial variant selectable
// RULE_10 - current loop turns high side off above limit, overriding voltage
// RULE_11 - high side follows output-below-reference comparator (pfm)
// RULE_12 - reference level chosen from output voltage select setting
// RULE_13 - sequencing bit controls changeover; only for 5.0 or 5.7 V; code does not check vsel, leaves it to software
// RULE_14 - serial variant buck off bit stops buck; pin variant cannot
// RULE_15 - limit select 0 means 600 mA, 1 means 150 mA
// RULE_16 - error pin low during undervoltage or overcurrent retry period
// RULE_17 - counters time deglitch and retry; deglitch restarts on dropout
package bkfc_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  // control field positions
  localparam int CTRL_OFF = 0;
  localparam int CTRL_CL = 1;
  localparam int CTRL_SEQ_DIS = 2;
  localparam int CTRL_VSEL_LO = 3;
  localparam logic [4:0] CTRL_RST = 5'h04;
  // status field positions (also interrupt layout)
  localparam int ST_GLOBAL = 0;
  localparam int ST_REG = 1;
  localparam int ST_UV = 2;
  localparam int ST_OC = 3;
  localparam int CMD_CLEAR = 0;
  // output select codes: 3.3, 4.0, 5.0, 5.7 volt
  localparam logic [1:0] VSEL_3V3 = 2'h0;
  localparam logic [1:0] VSEL_4V0 = 2'h1;
  localparam logic [1:0] VSEL_5V0 = 2'h2;
  localparam logic [1:0] VSEL_5V7 = 2'h3;
  // limit select codes
  localparam logic LIM_600MA = 1'b0;
  localparam logic LIM_150MA = 1'b1;
  // timing in ns at 40 mhz
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEGLITCH_NS = 10000;
  localparam int RETRY_NS = 5000000;
  localparam int SLEEP_RST_NS = 5000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int RETRY_CYC = RETRY_NS / CLK_PERIOD_NS;
  localparam int SLEEP_RST_CYC = (SLEEP_RST_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // control word carried as a struct
  typedef struct packed {
    logic [1:0] vsel;
    logic seq_dis;
    logic cl_sel;
    logic off;
  } bkfc_ctrl_t;
  // analog comparator inputs
  typedef struct packed {
    logic below_ref;
    logic over_limit;
    logic over_ocp;
    logic under_volt;
  } bkfc_cmp_t;
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_DEGL = 2'b01,
    OC_RETRY = 2'b11
  } bkfc_oc_state_t;
endpackage : bkfc_pkg

// ### verilog/bkfc_top.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module bkfc_top #(
  parameter int RETRY_CYCLES = bkfc_pkg::RETRY_CYC, // retry length
  parameter int DEGL_CYCLES = bkfc_pkg::DEGLITCH_CYC, // ocp deglitch
  parameter int SLEEP_CYCLES = bkfc_pkg::SLEEP_RST_CYC, // sleep pulse
  parameter bit SERIAL_VARIANT = 1'b1 // 0: pin-configured part
) (
  input wire logic ref_clk_i, // 40 mhz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire bkfc_pkg::bkfc_cmp_t cmp_i, // comparator levels
  input wire logic [1:0] pin_vsel_i, // pin-variant voltage select
  input wire logic sleep_request_low_i, // sleep pin, active low
  output logic hs_on_o, // high-side switch gate
  output logic ls_on_o, // low-side switch gate
  output logic [1:0] regulator_reference_level_o, // reference select
  output logic ocp_600ma_o, // 1: 600 mA ocp threshold
  output logic avdd_from_buck_o, // avdd fed by buck output
  output logic error_pin_n_o, // open-drain data, always 0
  output logic error_pin_oe_n_o, // enable, low while pulling
  output logic irq_o // level interrupt
);
  import bkfc_pkg::*;

  initial begin
    // every counter shares the retry width, so no count may exceed retry
    if (RETRY_CYCLES < 2 || DEGL_CYCLES < 1 || SLEEP_CYCLES < 1 ||
        DEGL_CYCLES > RETRY_CYCLES || SLEEP_CYCLES > RETRY_CYCLES)
      $error("bkfc_top: timing counts out of range");
  end

  localparam int CW = $clog2(RETRY_CYCLES + 1);

  bkfc_ctrl_t ctrl_reg;
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  bkfc_oc_state_t oc_state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] slp_cnt_reg;
  logic sleep_clr;
  logic clear_cmd;
  logic stat_rd;
  logic wr_acc;
  logic rd_acc;
  logic buck_run;
  logic uv_evt;
  logic oc_evt;
  logic retrying;
  logic [3:0] stat_set;

  //----------------------------------------------------------------------
  // apb slave
  //----------------------------------------------------------------------
  // zero wait states: pready is held high so every access ends at once
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign clear_cmd = wr_acc && paddr_i == ADDR_CMD && pwdata_i[CMD_CLEAR];
  assign stat_rd = rd_acc && paddr_i == ADDR_STAT;

  // decode helper, used by error flag only; read mux decodes with its own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_MASK ||
             a == ADDR_CMD;
  endfunction : mapped

  // control and mask registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= 4'h0;
    end else if (wr_acc) begin
      if (paddr_i == ADDR_CTRL) begin
        ctrl_reg <= pwdata_i[4:0];
      end
      if (paddr_i == ADDR_MASK) begin
        mask_reg <= pwdata_i[3:0];
      end
    end
  end

  // read data, error and ready
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      pslverr_o <= psel_i & ~penable_i & ~mapped(paddr_i);
      if (psel_i & ~penable_i & ~pwrite_i) begin
        case (paddr_i)
          ADDR_CTRL: prdata_o <= {27'h0, ctrl_reg};
          ADDR_STAT: prdata_o <= {28'h0, stat_reg | stat_set};
          ADDR_MASK: prdata_o <= {28'h0, mask_reg};
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end

  //----------------------------------------------------------------------
  // sleep pin reset pulse
  //----------------------------------------------------------------------
  // short glitches low are ignored; only a long enough pulse clears
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slp_cnt_reg <= '0;
    end else if (sleep_request_low_i) begin
      slp_cnt_reg <= '0;
    end else if (slp_cnt_reg < CW'(SLEEP_CYCLES)) begin
      slp_cnt_reg <= slp_cnt_reg + CW'(1);
    end
  end
  // clear fires on release after a long low
  assign sleep_clr = sleep_request_low_i &&
                     slp_cnt_reg >= CW'(SLEEP_CYCLES); // RULE_04

  //----------------------------------------------------------------------
  // overcurrent deglitch and retry
  //----------------------------------------------------------------------
  assign buck_run = ~(SERIAL_VARIANT & ctrl_reg.off); // RULE_14
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oc_state_reg <= OC_IDLE;
      cnt_reg <= '0;
    end else begin
      case (oc_state_reg)
        OC_IDLE: begin
          cnt_reg <= '0;
          if (cmp_i.over_ocp && buck_run) begin
            oc_state_reg <= OC_DEGL;
            cnt_reg <= CW'(1);
          end
        end
        OC_DEGL: begin
          if (!cmp_i.over_ocp || !buck_run) begin
            oc_state_reg <= OC_IDLE; // RULE_17
            cnt_reg <= '0;
          end else if (cnt_reg >= CW'(DEGL_CYCLES)) begin
            oc_state_reg <= OC_RETRY; // RULE_05
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + CW'(1);
          end
        end
        OC_RETRY: begin
          if (cnt_reg >= CW'(RETRY_CYCLES - 1)) begin
            oc_state_reg <= OC_IDLE; // RULE_07
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + CW'(1); // RULE_17
          end
        end
        default: begin
          oc_state_reg <= OC_IDLE;
          cnt_reg <= '0;
        end
      endcase
    end
  end
  assign retrying = oc_state_reg == OC_RETRY;
  assign oc_evt = oc_state_reg == OC_DEGL && cmp_i.over_ocp && buck_run &&
                  cnt_reg >= CW'(DEGL_CYCLES);
  assign uv_evt = cmp_i.under_volt;

  //----------------------------------------------------------------------
  // status flags
  //----------------------------------------------------------------------
  assign stat_set[ST_UV] = uv_evt; // RULE_02
  assign stat_set[ST_OC] = oc_evt; // RULE_06
  assign stat_set[ST_REG] = uv_evt | oc_evt;
  assign stat_set[ST_GLOBAL] = uv_evt | oc_evt;

  // set beats every clear; overcurrent flags also track the retry window
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_reg <= 4'h0;
    end else begin
      if (clear_cmd || sleep_clr || stat_rd) begin
        stat_reg[ST_UV] <= uv_evt; // RULE_04
      end else if (uv_evt) begin
        stat_reg[ST_UV] <= 1'b1;
      end
      // held through retry, dropped when it expires
      stat_reg[ST_OC] <= oc_evt | retrying & ~(cnt_reg >=
                         CW'(RETRY_CYCLES - 1)); // RULE_08
      if (clear_cmd || sleep_clr || stat_rd) begin
        stat_reg[ST_REG] <= stat_set[ST_REG] | retrying;
        stat_reg[ST_GLOBAL] <= stat_set[ST_GLOBAL] | retrying;
      end else if (stat_set[ST_REG]) begin
        stat_reg[ST_REG] <= 1'b1;
        stat_reg[ST_GLOBAL] <= 1'b1;
      end else if (retrying && cnt_reg >= CW'(RETRY_CYCLES - 1) &&
                   !stat_reg[ST_UV]) begin
        stat_reg[ST_REG] <= 1'b0; // RULE_08
        stat_reg[ST_GLOBAL] <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------
  // switch control and outputs
  //----------------------------------------------------------------------
  // pfm: high side follows comparator, current loop and faults override
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hs_on_o <= 1'b0;
      ls_on_o <= 1'b0;
    end else begin
      hs_on_o <= cmp_i.below_ref // RULE_11
                 & ~cmp_i.over_limit // RULE_10
                 & ~uv_evt // RULE_01 RULE_03
                 & ~oc_evt & ~retrying & buck_run; // RULE_07
      ls_on_o <= ~cmp_i.below_ref & ~uv_evt & ~oc_evt & ~retrying &
                 buck_run; // RULE_01
    end
  end

  // error pin pulls low during undervoltage or retry window
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      error_pin_oe_n_o <= 1'b1;
      error_pin_n_o <= 1'b0;
    end else begin
      error_pin_n_o <= 1'b0;
      error_pin_oe_n_o <= ~(uv_evt | oc_evt |
                           (retrying & ~(cnt_reg >=
                           CW'(RETRY_CYCLES - 1)))); // RULE_16
    end
  end

  // configuration outputs
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      regulator_reference_level_o <= VSEL_3V3;
      ocp_600ma_o <= 1'b1;
      avdd_from_buck_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      regulator_reference_level_o <= SERIAL_VARIANT ? ctrl_reg.vsel :
                                     pin_vsel_i; // RULE_12
      ocp_600ma_o <= ~SERIAL_VARIANT |
                     (ctrl_reg.cl_sel == LIM_600MA); // RULE_09 RULE_15
      // software only clears the disable bit for 5.0 or 5.7 volt
      avdd_from_buck_o <= ~ctrl_reg.seq_dis & buck_run; // RULE_13
      irq_o <= |((stat_reg | stat_set) & mask_reg);
    end
  end

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  AST_UV_OFF: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmp_i.under_volt |=> !hs_on_o && !ls_on_o && !error_pin_oe_n_o)
    else $error("undervoltage did not stop buck"); // RULE_01
  AST_UV_FLAG: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmp_i.under_volt |=> stat_reg[ST_UV] && stat_reg[ST_REG] &&
    stat_reg[ST_GLOBAL]) else $error("uv flags not set"); // RULE_02
  AST_UV_STICKY: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    stat_reg[ST_UV] && !clear_cmd && !sleep_clr && !stat_rd |=>
    stat_reg[ST_UV]) else $error("uv flag lost"); // RULE_04
  AST_OC_RETRY: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    oc_evt |=> retrying && !error_pin_oe_n_o && !hs_on_o)
    else $error("ocp not acted on"); // RULE_05
  AST_OC_FLAG: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    oc_evt |=> stat_reg[ST_OC] && stat_reg[ST_GLOBAL])
    else $error("ocp flags not set"); // RULE_06
  AST_DEGL_RESTART: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    oc_state_reg == OC_DEGL && !cmp_i.over_ocp |=> oc_state_reg == OC_IDLE)
    else $error("deglitch not restarted"); // RULE_17
  AST_CUR_LIMIT: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    cmp_i.over_limit |=> !hs_on_o) else $error("limit ignored"); // RULE_10
  AST_PFM: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !cmp_i.below_ref |=> !hs_on_o) else $error("hs on above ref"); // RULE_11
  AST_RETRY_END: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    $fell(retrying) && !oc_evt |-> !stat_reg[ST_OC])
    else $error("ocp flag outlived retry"); // RULE_08
  AST_OFF: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    SERIAL_VARIANT && ctrl_reg.off |=> !hs_on_o)
    else $error("buck off ignored"); // RULE_14
  COV_UV: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmp_i.under_volt ##1 !cmp_i.under_volt);
  COV_OC: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    oc_evt);
  COV_RETRY_DONE: cover property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) $fell(retrying));
endmodule : bkfc_top

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import bkfc_pkg::*;
  //----------------------------------------------------------------------
  // clock, reset and stimulus
  //----------------------------------------------------------------------
  localparam int RETRY = 20;
  localparam int DEGL = 4;
  localparam int SLP = 4;
  logic ref_clk, sys_rst, psel, penable, pwrite, sleep_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, hs_on, ls_on, ocp_600ma, avdd_buck, pin_n, pin_oe_n;
  logic irq;
  logic [1:0] ref_lvl;
  // pin-configured instance: fixed limit, no off bit, pin voltage select
  logic [1:0] pin_vsel, p_ref_lvl;
  logic p_hs_on, p_ocp;
  bkfc_cmp_t cmp;
  int errors;
  int n_tests;
  // short counts keep the retry scenario within a few hundred cycles
  bkfc_top #(.RETRY_CYCLES(RETRY), .DEGL_CYCLES(DEGL),
    .SLEEP_CYCLES(SLP), .SERIAL_VARIANT(1'b1)) DUT (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cmp_i(cmp), .pin_vsel_i(pin_vsel),
    .sleep_request_low_i(sleep_n), .hs_on_o(hs_on), .ls_on_o(ls_on),
    .regulator_reference_level_o(ref_lvl), .ocp_600ma_o(ocp_600ma),
    .avdd_from_buck_o(avdd_buck), .error_pin_n_o(pin_n),
    .error_pin_oe_n_o(pin_oe_n), .irq_o(irq));
  bkfc_top #(.RETRY_CYCLES(RETRY), .DEGL_CYCLES(DEGL),
    .SLEEP_CYCLES(SLP), .SERIAL_VARIANT(1'b0)) DUT_PIN (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(), .pready_o(),
    .pslverr_o(), .cmp_i(cmp), .pin_vsel_i(pin_vsel),
    .sleep_request_low_i(sleep_n), .hs_on_o(p_hs_on), .ls_on_o(),
    .regulator_reference_level_o(p_ref_lvl), .ocp_600ma_o(p_ocp),
    .avdd_from_buck_o(), .error_pin_n_o(),
    .error_pin_oe_n_o(), .irq_o());
  // free running clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  //----------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // one apb transfer; waits for pready with a bound, idles one cycle after
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] ex, input logic ex_err);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
    chk({nm, "_err"}, {31'h0, ex_err}, {31'h0, e});
  endtask : rd_chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    errors++;
    test_done();
  end
  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmp = '0;
    sleep_n = 1'b1;
    pin_vsel = 2'h3;
    cyc(16);
    chk("rst_oe_n", 32'h1, {31'h0, pin_oe_n});
    chk("rst_600ma", 32'h1, {31'h0, ocp_600ma});
    sys_rst <= 1'b0;
    cyc(1);
    rd_chk("ctrl_rst", ADDR_CTRL, {27'h0, CTRL_RST}, 1'b0);
    rd_chk("unmapped", 8'h10, 32'h0, 1'b1);
    // voltage select and sequencing, enabled only for 5.0 / 5.7 V
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_CTRL, {27'h0, v[1:0], ~v[1], 2'b00});
      cyc(2);
      chk("ref_lvl", {30'h0, v[1:0]}, {30'h0, ref_lvl});
      chk("avdd_buck", {31'h0, v[1]}, {31'h0, avdd_buck});
    end
    wr(ADDR_CTRL, 32'h12);
    cyc(2);
    chk("lim_150", 32'h0, {31'h0, ocp_600ma});
    chk("pin_600ma", 32'h1, {31'h0, p_ocp});
    chk("pin_ref", 32'h3, {30'h0, p_ref_lvl});
    wr(ADDR_CTRL, 32'h10);
    cyc(2);
    chk("lim_600", 32'h1, {31'h0, ocp_600ma});
    // pfm: high side follows comparator, current loop overrides
    cmp.below_ref <= 1'b1;
    cyc(3);
    chk("hs_pfm_on", 32'h1, {31'h0, hs_on});
    cmp.over_limit <= 1'b1;
    cyc(3);
    chk("hs_limit", 32'h0, {31'h0, hs_on});
    cmp.over_limit <= 1'b0;
    cmp.below_ref <= 1'b0;
    cyc(3);
    chk("hs_pfm_off", 32'h0, {31'h0, hs_on});
    cmp.below_ref <= 1'b1;
    wr(ADDR_CTRL, 32'h11);
    cyc(2);
    chk("hs_disabled", 32'h0, {31'h0, hs_on});
    chk("pin_no_off", 32'h1, {31'h0, p_hs_on});
    wr(ADDR_CTRL, 32'h10);
    cyc(3);
    chk("hs_enabled", 32'h1, {31'h0, hs_on});
    // undervoltage: gates off, pin low, sticky flag seen through irq
    wr(ADDR_MASK, 32'h4);
    for (int k = 0; k < 2; k++) begin
      cmp.under_volt <= 1'b1;
      cyc(3);
      chk("uv_hs", 32'h0, {31'h0, hs_on});
      chk("uv_ls", 32'h0, {31'h0, ls_on});
      chk("uv_pin", 32'h0, {31'h0, pin_oe_n});
      chk("pin_data", 32'h0, {31'h0, pin_n});
      rd_chk("uv_stat", ADDR_STAT, 32'h7, 1'b0);
      cmp.under_volt <= 1'b0;
      cyc(3);
      chk("uv_pin_rel", 32'h1, {31'h0, pin_oe_n});
      chk("uv_hs_back", 32'h1, {31'h0, hs_on});
      chk("uv_sticky", 32'h1, {31'h0, irq});
      if (k == 0) begin
        wr(ADDR_CMD, 32'h1);
      end else begin
        sleep_n <= 1'b0;
        cyc(SLP - 2);
        sleep_n <= 1'b1;
        cyc(3);
        chk("uv_short_slp", 32'h1, {31'h0, irq});
        sleep_n <= 1'b0;
        cyc(SLP + 2);
        sleep_n <= 1'b1;
      end
      cyc(3);
      chk("uv_cleared", 32'h0, {31'h0, irq});
    end
    // overcurrent: interrupted pulses never reach the deglitch time
    wr(ADDR_MASK, 32'h8);
    for (int k = 0; k < 2; k++) begin
      cmp.over_ocp <= 1'b1;
      cyc(DEGL - 1);
      cmp.over_ocp <= 1'b0;
      cyc(1);
    end
    cyc(2);
    chk("oc_glitch", 32'h1, {31'h0, pin_oe_n});
    chk("oc_glitch_irq", 32'h0, {31'h0, irq});
    cmp.over_ocp <= 1'b1;
    cyc(DEGL + 4);
    cmp.over_ocp <= 1'b0;
    chk("oc_pin", 32'h0, {31'h0, pin_oe_n});
    chk("oc_irq", 32'h1, {31'h0, irq});
    cyc(RETRY / 2);
    chk("oc_hold_pin", 32'h0, {31'h0, pin_oe_n});
    chk("oc_hold_hs", 32'h0, {31'h0, hs_on});
    rd_chk("oc_stat", ADDR_STAT, 32'hB, 1'b0);
    cyc(RETRY);
    chk("oc_pin_rel", 32'h1, {31'h0, pin_oe_n});
    chk("oc_hs_back", 32'h1, {31'h0, hs_on});
    chk("oc_irq_clr", 32'h0, {31'h0, irq});
    rd_chk("oc_stat_clr", ADDR_STAT, 32'h0, 1'b0);
    test_done();
  end
endmodule : tb_top
